// *** dsl_activation_consts.vh ***
`ifndef DSL_ACTIVATION_CONSTS_VH
`define DSL_ACTIVATION_CONSTS_VH

// register word offsets
`define REG_CONTROL 2'h0
`define REG_STATUS 2'h1
`define REG_LOSS 2'h2

// control fields
`define CTL_ACT_REQ 0
`define CTL_ROLE_CUST 1
`define CTL_SINGLE_EN 2
`define CTL_CAP_2D 3
`define CTL_CAP_4D 4
`define CTL_MID_HIGH 5
`define CTL_RESET_VAL 32'h0000_0018

// status fields
`define STS_STATE_LSB 0
`define STS_REPLIED_LSB 4
`define STS_CODE4D 6
`define STS_HIGH_PWR 7
`define STS_SINGLE 8
`define STS_ALERTED 9
`define STS_ACT_EXP 10
`define STS_TRAIN_ON 11
`define STS_POWER_SET 12

// line loss limits in dB
`define LOSS_HIGH_DB 8'h09
`define LOSS_LOW_DB 8'h06

// wake generator seed, bits [5:0]
`define WAKE_SEED 6'h20

// timer figures in symbol intervals
`define WAKE_LEN_SYM 126
`define T1_SYM 2600
`define T2_SYM 160001
`define T3_SYM 130000
`define T4_SYM 400
`define TRAIN_EX_SYM 1240000
`define TRAIN_CU_SYM 3300
`define ACT_SYM 2500000

`endif

// *** wake_pn_gen.v ***
`timescale 1ns/1ps
`include "dsl_activation_consts.vh"

module wake_pn_gen (
	// clock, reset and enable
	input wire clk_i,
	input wire rst_i,
	input wire ce_i,
	// control
	input wire load_i,
	input wire step_i,
	// symbol bit, 1 maps to +A and 0 to -A
	output reg bit_o
);

reg [5:0] stage;
wire fb;

// stage[0] is oldest; taps at delays 5 and 6, input held at one
assign fb = 1'b1 ^ stage[1] ^ stage[0];

always @(posedge clk_i) begin
	if (rst_i) begin
		stage <= `WAKE_SEED;
		bit_o <= 1'b0;
	end else if (ce_i) begin
		if (load_i) begin
			stage <= `WAKE_SEED; // [R23]
			bit_o <= 1'b0;
		end else if (step_i) begin
			stage <= {fb, stage[5:1]}; // [R23]
			bit_o <= fb;
		end
	end
end

endmodule // wake_pn_gen

// *** dsl_activation_alerting.v ***
// What this block does
// R1 - exchange wakes channel A, then listens silently
// R2 - customer answers wake on same channel
// R3 - reply on A, then wake B; B reply alerts
// R4 - no reply in wait time: poll other channel
// R5 - one replied: poll other until reply/timeout
// R6 - exchange alerts only while request is set
// R7 - customer reply starts fallback timer
// R8 - single-code unit sends and answers own variant
// R9 - dual-code exchange polls 2D A,B then 4D A,B
// R10 - dual-code customer waits for second 4D poll
// R11 - after reply, same code on other channel
// R12 - single mode: alternate wake/silence on channel
// R13 - fallback expiry: single mode, reply again
// R14 - done only once exchange sends training
// R15 - reply starts second-reply timer
// R16 - single mode: training after start delay
// R17 - second-reply timeout: retry with wake again
// R18 - power chosen from measured wake loss
// R19 - chosen power held through activation
// R20 - exchange training length 1240 kT
// R21 - customer training length 3300 T
// R22 - customer starts training within detect limit
// R23 - wake is six-stage PN, seed 000001
// R24 - wait time 2250..3000, reply timer >160000
// R25 - fallback 115k..150k, delays below 500/200
// R26 - activation timer starts at training (customer) or at first reply (exchange)
// R27 - timers count symbols, restart from zero
`timescale 1ns/1ps
`include "dsl_activation_consts.vh"

module dsl_activation_alerting #(
	parameter TW = 22,
	parameter WAKE_LEN = `WAKE_LEN_SYM,
	parameter T1_SYM = `T1_SYM,
	parameter T2_SYM = `T2_SYM,
	parameter T3_SYM = `T3_SYM,
	parameter T4_SYM = `T4_SYM,
	parameter TRAIN_EX_SYM = `TRAIN_EX_SYM,
	parameter TRAIN_CU_SYM = `TRAIN_CU_SYM,
	parameter ACT_SYM = `ACT_SYM
) (
	// clock, reset, enable
	input wire clk_i,
	input wire rst_i,
	input wire ce_i,
	// symbol interval strobe
	input wire sym_tick_i,
	// avalon-mm slave
	input wire [1:0] avs_address_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire [31:0] avs_writedata_i,
	output reg [31:0] avs_readdata_o,
	output wire avs_waitrequest_o,
	// per-channel detectors, bit 0 channel A, and the single 8-bit line loss figure
	input wire [1:0] wake_det_i,
	input wire [1:0] wake_code4d_i,
	input wire [1:0] train_det_i,
	input wire [7:0] line_loss_i,
	// line transmit control
	output reg [1:0] tx_wake_o,
	output wire tx_wake_bit_o,
	output reg tx_code4d_o,
	output reg [1:0] tx_train_o,
	output reg high_power_mode_o,
	output reg alerted_o
);

localparam S_IDLE = 4'h0;
localparam S_WAKE = 4'h1;
localparam S_LISTEN = 4'h2;
localparam S_DELAY = 4'h3;
localparam S_TRAIN = 4'h4;
localparam S_DONE = 4'h5;
localparam S_FAIL = 4'h6;
localparam S_CWAIT = 4'h7;
localparam S_TWAIT = 4'h8;

// last count of a timer, cut to the timer width
function [TW-1:0] last_count;
	input integer n;
	begin
		last_count = n[TW-1:0] - {{(TW-1){1'b0}}, 1'b1};
	end
endfunction

localparam [TW-1:0] WAKE_END = last_count(WAKE_LEN);
localparam [TW-1:0] T1_END = last_count(T1_SYM); // [R24]
localparam [TW-1:0] T2_END = last_count(T2_SYM); // [R24]
localparam [TW-1:0] T3_END = last_count(T3_SYM); // [R25]
localparam [TW-1:0] T4_END = last_count(T4_SYM); // [R25]
localparam [TW-1:0] TREX_END = last_count(TRAIN_EX_SYM);
localparam [TW-1:0] TRCU_END = last_count(TRAIN_CU_SYM);
localparam [TW-1:0] ACT_END = last_count(ACT_SYM);

function [1:0] ch_mask;
	input ch;
	begin
		ch_mask = ch ? 2'h2 : 2'h1;
	end
endfunction

function [TW-1:0] bump;
	input [TW-1:0] cnt;
	begin
		bump = cnt + {{(TW-1){1'b0}}, 1'b1};
	end
endfunction

// registers
reg [31:0] control;
reg ack;
wire req_on = (avs_read_i | avs_write_i) & ~ack;
assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack;

wire act_req = control[`CTL_ACT_REQ];
wire role_cust = control[`CTL_ROLE_CUST];
wire single_en = control[`CTL_SINGLE_EN];
wire cap2d = control[`CTL_CAP_2D];
wire cap4d = control[`CTL_CAP_4D];

// sequencer state
reg [3:0] state;
reg ch;
reg first_ch;
reg code4d;
reg code_lock;
reg [1:0] replied;
reg single;
reg [TW-1:0] tmr;
reg [TW-1:0] t23;
reg t23_run;
reg [TW-1:0] act;
reg act_run;
reg act_exp;
reg seen2d;
reg seen4d;
reg power_set;
reg pn_load;

wire tick = sym_tick_i;
wire [1:0] rx_ok;
wire [1:0] rx_dual;
wire det_on_ch = wake_det_i[ch] & (wake_code4d_i[ch] == code4d);
wire det_other = wake_det_i[~ch] & (wake_code4d_i[~ch] == code4d);
wire [1:0] cand = wake_det_i & rx_ok;
wire cand_ch = ~cand[0];

// customer acceptance of a poll per channel
genvar g;
generate
	for (g = 0; g < 2; g = g + 1) begin : g_acc
		assign rx_dual[g] = wake_code4d_i[g] ? (seen4d & ~seen2d) : 1'b1;
		assign rx_ok[g] = wake_code4d_i[g] ?
			(cap4d & (~cap2d | rx_dual[g])) : cap2d; // [R8] [R10]
	end
endgenerate

// bus slave, one wait state per access
always @(posedge clk_i) begin
	if (rst_i) begin
		ack <= 1'b0;
		control <= `CTL_RESET_VAL;
		avs_readdata_o <= 32'h0000_0000;
	end else if (ce_i) begin
		ack <= req_on;
		if (avs_write_i & ack & avs_address_i == `REG_CONTROL)
			control <= {26'h0, avs_writedata_i[5:0]};
		if (req_on & avs_read_i) begin
			case (avs_address_i)
			`REG_CONTROL: avs_readdata_o <= control;
			`REG_STATUS: avs_readdata_o <= {19'h0, power_set, |tx_train_o,
				act_exp, alerted_o, single, high_power_mode_o, code4d,
				replied, state};
			`REG_LOSS: avs_readdata_o <= {24'h0, line_loss_i};
			default: avs_readdata_o <= 32'h0000_0000;
			endcase
		end
	end
end

// wake bit source
wake_pn_gen u_pn (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.ce_i(ce_i),
	.load_i(pn_load),
	.step_i(tick & state == S_WAKE),
	.bit_o(tx_wake_bit_o)
);

// power mode, caught once at the first wake seen
always @(posedge clk_i) begin
	if (rst_i) begin
		power_set <= 1'b0;
		high_power_mode_o <= 1'b0;
	end else if (ce_i) begin
		if (state == S_IDLE & ~act_req)
			power_set <= 1'b0;
		else if (~power_set & |wake_det_i) begin
			power_set <= 1'b1; // [R19]
			if (line_loss_i > `LOSS_HIGH_DB)
				high_power_mode_o <= 1'b1; // [R18]
			else if (line_loss_i < `LOSS_LOW_DB)
				high_power_mode_o <= 1'b0; // [R18]
			else
				high_power_mode_o <= control[`CTL_MID_HIGH]; // [R18]
		end
	end
end

// activation timer
always @(posedge clk_i) begin
	if (rst_i) begin
		act <= {TW{1'b0}};
		act_run <= 1'b0;
		act_exp <= 1'b0;
	end else if (ce_i) begin
		if (state == S_IDLE) begin
			act_run <= 1'b0;
			act_exp <= 1'b0;
		end else if ((role_cust & state == S_TWAIT & |train_det_i) |
			(~role_cust & state == S_TRAIN & |train_det_i & ~act_run) |
			(~role_cust & state == S_LISTEN & det_on_ch & replied == 2'h0)) begin
			act <= {TW{1'b0}}; // [R26] [R27]
			act_run <= 1'b1;
		end else if (act_run & tick) begin
			if (act == ACT_END) begin
				act_run <= 1'b0;
				act_exp <= 1'b1;
			end else
				act <= bump(act); // [R27]
		end
	end
end

// sequencer
always @(posedge clk_i) begin
	if (rst_i) begin
		state <= S_IDLE;
		ch <= 1'b0;
		first_ch <= 1'b0;
		code4d <= 1'b0;
		code_lock <= 1'b0;
		replied <= 2'h0;
		single <= 1'b0;
		tmr <= {TW{1'b0}};
		t23 <= {TW{1'b0}};
		t23_run <= 1'b0;
		seen2d <= 1'b0;
		seen4d <= 1'b0;
		pn_load <= 1'b1;
	end else if (ce_i) begin
		pn_load <= 1'b0;
		if (tick & t23_run)
			t23 <= bump(t23); // [R27]
		if (tick & state != S_IDLE)
			tmr <= bump(tmr); // [R27]
		if (state != S_IDLE & ~act_req) begin
			state <= S_IDLE; // [R6]
		end else begin
			case (state)
			S_IDLE: begin
				replied <= 2'h0;
				single <= 1'b0;
				code_lock <= 1'b0;
				t23_run <= 1'b0;
				tmr <= {TW{1'b0}};
				pn_load <= 1'b1;
				if (act_req & ~role_cust) begin
					ch <= 1'b0; // [R1]
					code4d <= ~cap2d; // [R8] [R9]
					state <= S_WAKE; // [R6]
				end else if (act_req & role_cust) begin
					if (|wake_det_i) begin
						seen2d <= seen2d | |(wake_det_i & ~wake_code4d_i);
						seen4d <= seen4d | |(wake_det_i & wake_code4d_i);
					end
					if (|cand) begin
						ch <= cand_ch; // [R2]
						first_ch <= cand_ch;
						code4d <= wake_code4d_i[cand_ch];
						state <= S_WAKE; // [R2] [R10]
					end
				end
			end
			S_WAKE: begin
				if (tick & tmr == WAKE_END) begin
					tmr <= {TW{1'b0}};
					pn_load <= 1'b1;
					if (~role_cust) begin
						state <= S_LISTEN; // [R1] [R12]
					end else if (single | replied[~ch]) begin
						replied[ch] <= 1'b1;
						state <= S_TWAIT;
					end else begin
						replied[ch] <= 1'b1;
						t23 <= {TW{1'b0}}; // [R7] [R27]
						t23_run <= 1'b1;
						state <= S_CWAIT;
					end
				end
			end
			S_LISTEN: begin
				if (det_on_ch & ~replied[ch]) begin
					replied[ch] <= 1'b1; // [R3]
					code_lock <= 1'b1;
					tmr <= {TW{1'b0}};
					if (replied[~ch]) begin
						t23_run <= 1'b0;
						state <= S_DELAY; // [R3]
					end else begin
						first_ch <= ch;
						t23 <= {TW{1'b0}}; // [R15] [R27]
						t23_run <= 1'b1;
						ch <= ~ch; // [R3] [R11]
						state <= S_WAKE;
					end
				end else if (t23_run & single_en &
					wake_det_i[first_ch] &
					wake_code4d_i[first_ch] == code4d) begin
					ch <= first_ch;
					single <= 1'b1; // [R15]
					t23_run <= 1'b0;
					tmr <= {TW{1'b0}};
					state <= S_DELAY; // [R16]
				end else if (act_exp & replied != 2'h0) begin
					state <= S_FAIL; // [R5]
				end else if (t23_run & tick & t23 == T2_END) begin
					t23_run <= 1'b0;
					if (single_en) begin
						replied <= 2'h0; // [R17]
						ch <= first_ch;
						tmr <= {TW{1'b0}};
						state <= S_WAKE; // [R17]
					end
				end else if (tick & tmr == T1_END) begin
					tmr <= {TW{1'b0}};
					state <= S_WAKE; // [R4] [R5]
					if (replied == 2'h0) begin
						ch <= ~ch; // [R4]
						if (ch & cap2d & cap4d & ~code_lock)
							code4d <= ~code4d; // [R9]
					end
				end
			end
			S_DELAY: begin
				if (tick & tmr == T4_END) begin
					tmr <= {TW{1'b0}};
					state <= S_TRAIN; // [R14] [R16] [R20]
				end
			end
			S_CWAIT: begin
				if (det_other) begin
					ch <= ~ch; // [R7]
					t23_run <= 1'b0;
					tmr <= {TW{1'b0}};
					state <= S_WAKE; // [R7]
				end else if (tick & t23 == T3_END) begin
					t23_run <= 1'b0;
					single <= 1'b1; // [R13]
					tmr <= {TW{1'b0}};
					state <= S_WAKE; // [R13]
				end
			end
			S_TWAIT: begin
				if (|train_det_i) begin
					tmr <= {TW{1'b0}};
					state <= S_TRAIN; // [R22]
				end
			end
			S_TRAIN: begin
				if (tick & tmr == (role_cust ? TRCU_END : TREX_END))
					state <= S_DONE; // [R20] [R21]
			end
			S_DONE: state <= S_DONE;
			S_FAIL: state <= S_FAIL;
			default: state <= S_IDLE;
			endcase
		end
	end
end

// registered line controls
always @(posedge clk_i) begin
	if (rst_i) begin
		tx_wake_o <= 2'h0;
		tx_code4d_o <= 1'b0;
		tx_train_o <= 2'h0;
		alerted_o <= 1'b0;
	end else if (ce_i) begin
		tx_wake_o <= (state == S_WAKE) ? ch_mask(ch) : 2'h0; // [R1] [R2]
		tx_code4d_o <= code4d; // [R8]
		if (state == S_TRAIN)
			tx_train_o <= single ? ch_mask(ch) : 2'h3; // [R20] [R21]
		else
			tx_train_o <= 2'h0;
		alerted_o <= (state == S_TRAIN) | (state == S_DONE); // [R14]
	end
end

endmodule // dsl_activation_alerting

// *** dsl_activation_alerting_checker.sv ***
`timescale 1ns/1ps
module dsl_activation_alerting_checker #(
	parameter WAKE_LEN = 8,
	parameter TRAIN_EX_SYM = 50,
	parameter TRAIN_CU_SYM = 30
) (
	// watched ports
	input wire clk_i,
	input wire rst_i,
	input wire ce_i,
	input wire sym_tick_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire avs_waitrequest_o,
	input wire [1:0] tx_wake_o,
	input wire [1:0] tx_train_o,
	input wire high_power_mode_o,
	input wire alerted_o
);
	reg [31:0] wk_n;
	reg [31:0] tr_n;
	// symbol ticks within the running burst
	always @(posedge clk_i) begin
		wk_n <= |tx_wake_o ? wk_n + (sym_tick_i & ce_i) : 32'h0;
		tr_n <= |tx_train_o ? tr_n + (sym_tick_i & ce_i) : 32'h0;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_one;
		$onehot0(tx_wake_o);
	endproperty
	a_one: assert property (p_one) else $error("two wake channels");
	property p_ack;
		$rose(avs_read_i | avs_write_i) |->
			avs_waitrequest_o ##1 !avs_waitrequest_o;
	endproperty
	a_ack: assert property (p_ack) else $error("bus wait state wrong");
	property p_quiet;
		(|tx_wake_o) ##1 !(|tx_wake_o) |-> ##1 !(|tx_wake_o);
	endproperty
	a_quiet: assert property (p_quiet) else $error("no silence");
	property p_wlen;
		$fell(|tx_wake_o) |-> wk_n >= WAKE_LEN - 1 && wk_n <= WAKE_LEN + 1;
	endproperty
	a_wlen: assert property (p_wlen) else $error("wake length");
	property p_tlen;
		$fell(|tx_train_o) |-> tr_n inside {[TRAIN_EX_SYM - 1:TRAIN_EX_SYM + 1],
			[TRAIN_CU_SYM - 1:TRAIN_CU_SYM + 1]};
	endproperty
	a_tlen: assert property (p_tlen) else $error("train length");
	property p_mix;
		!((|tx_wake_o) && (|tx_train_o));
	endproperty
	a_mix: assert property (p_mix) else $error("wake during training");
	property p_talert;
		(|tx_train_o) ##1 (|tx_train_o) |-> alerted_o;
	endproperty
	a_talert: assert property (p_talert) else $error("train not alerted");
	property p_hold;
		alerted_o && $past(alerted_o) |-> $stable(high_power_mode_o);
	endproperty
	a_hold: assert property (p_hold) else $error("power changed");
	property p_tstart;
		$rose(|tx_train_o) |-> !$past(|tx_wake_o);
	endproperty
	a_tstart: assert property (p_tstart) else $error("no gap");
	cover property (tx_wake_o == 2'h2);
	cover property (tx_train_o == 2'h3);
	cover property (tx_train_o == 2'h1);
	cover property (high_power_mode_o && alerted_o);
endmodule // dsl_activation_alerting_checker

// *** far_peer.sv ***
`timescale 1ns/1ps
module far_peer (
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// behaviour control
	input wire [1:0] mute_i,
	input wire [7:0] dly_i,
	// line seen from the design
	input wire [1:0] wake_i,
	input wire code_i,
	input wire [1:0] train_i,
	// detector outputs to the design
	output reg [1:0] det_o,
	output reg [1:0] code4d_o,
	output wire [1:0] train_det_o
);
	reg [1:0] prev;
	reg [1:0] pend;
	reg [7:0] wait_n;
	reg c4;
	// training answered on every unmuted channel
	assign train_det_o = train_i & ~mute_i;
	always @(posedge clk_i) begin
		prev <= wake_i;
		det_o <= 2'h0;
		if (|wake_i)
			c4 <= code_i;
		if (rst_i) begin
			pend <= 2'h0;
			code4d_o <= 2'h0;
		end else if (|(prev & ~wake_i & ~mute_i)) begin
			pend <= prev & ~wake_i;
			wait_n <= dly_i;
		end else if (|pend) begin
			if (wait_n == 8'h00) begin
				det_o <= pend;
				code4d_o <= {2{c4}};
				pend <= 2'h0;
			end else
				wait_n <= wait_n - 8'h01;
		end
	end
endmodule // far_peer

// *** dsl_activation_alerting_tb_top.sv ***
`timescale 1ns/1ps
module dsl_activation_alerting_tb_top;
	reg clk_i = 0, rst_i = 1, ce_i = 1, sym_tick_i = 0;
	reg [1:0] avs_address_i = 2'h0;
	reg avs_read_i = 0, avs_write_i = 0;
	reg [31:0] avs_writedata_i = 32'h0;
	reg [7:0] line_loss_i = 8'h0A, dly = 8'h03;
	reg [1:0] mute = 2'h0, tb_det = 2'h0, tb_c4 = 2'h0, tb_train = 2'h0;
	wire [31:0] avs_readdata_o;
	wire avs_waitrequest_o, tx_wake_bit_o, tx_code4d_o, high_power_mode_o;
	wire alerted_o;
	wire [1:0] tx_wake_o, tx_train_o, pk_det, pk_c4, pk_train;
	reg [31:0] q;
	int err_total = 0, total_checks = 0, cyc = 0;
	dsl_activation_alerting #(.T1_SYM(20), .T2_SYM(200), .T3_SYM(150),
		.TRAIN_EX_SYM(50), .ACT_SYM(2000)) dut (.clk_i(clk_i),
		.rst_i(rst_i), .ce_i(ce_i),
		.sym_tick_i(sym_tick_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .wake_det_i(pk_det | tb_det),
		.wake_code4d_i(|tb_det ? tb_c4 : pk_c4),
		.train_det_i(pk_train | tb_train), .line_loss_i(line_loss_i),
		.tx_wake_o(tx_wake_o), .tx_wake_bit_o(tx_wake_bit_o),
		.tx_code4d_o(tx_code4d_o), .tx_train_o(tx_train_o),
		.high_power_mode_o(high_power_mode_o), .alerted_o(alerted_o));
	far_peer peer (.clk_i(clk_i), .rst_i(rst_i), .mute_i(mute), .dly_i(dly),
		.wake_i(tx_wake_o), .code_i(tx_code4d_o), .train_i(tx_train_o),
		.det_o(pk_det), .code4d_o(pk_c4), .train_det_o(pk_train));
	initial forever #2 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		sym_tick_i <= ~sym_tick_i;
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_total++;
			close_out;
		end
	end
	task close_out;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input [31:0] s, input [31:0] e);
		total_checks++;
		if (s !== e) begin
			err_total++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task bus(input w, input [1:0] a, input [31:0] d);
		@(posedge clk_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= w;
		avs_read_i <= !w;
		@(posedge clk_i);
		while (avs_waitrequest_o) @(posedge clk_i);
		q = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
	endtask
	task pulse(input [1:0] ch, input c4);
		@(posedge clk_i);
		tb_det <= ch;
		tb_c4 <= {2{c4}};
		@(posedge clk_i);
		tb_det <= 2'h0;
	endtask
	task reset;
		rst_i <= 1'b1;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
	endtask
	task run_ex(input [31:0] ctl, input [1:0] m);
		mute <= m;
		bus(1, 2'h0, ctl);
		wait (tx_wake_o == 2'h1);
	endtask
	initial begin
		reset;
		bus(0, 2'h0, 0); chk(q, 32'h18);
		bus(0, 2'h1, 0); chk(q, 32'h0);
		bus(1, 2'h2, 32'h55);
		bus(0, 2'h2, 0); chk(q, 32'h0A);
		bus(0, 2'h3, 0); chk(q, 32'h0);
		repeat (60) @(posedge clk_i);
		chk(tx_wake_o, 2'h0);
		run_ex(32'h19, 2'h0); chk(tx_code4d_o, 1'b0);
		ce_i <= 1'b0;
		q = tx_wake_bit_o;
		repeat (40) @(posedge clk_i);
		chk(tx_wake_bit_o, q);
		chk(tx_wake_o, 2'h1);
		ce_i <= 1'b1;
		wait (tx_wake_o == 2'h2);
		wait (tx_train_o == 2'h3); chk(high_power_mode_o, 1'b1);
		wait (tx_train_o == 2'h0);
		bus(0, 2'h1, 0); chk(q & 32'h128F, 32'h1285);
		bus(1, 2'h0, 32'h18);
		line_loss_i <= 8'h03;
		dly <= 8'h1E;
		run_ex(32'h19, 2'h1);
		wait (tx_wake_o == 2'h2);
		wait (tx_wake_o == 2'h1); chk(tx_code4d_o, 1'b0);
		mute <= 2'h0;
		wait (tx_train_o == 2'h3); chk(high_power_mode_o, 1'b0);
		wait (tx_train_o == 2'h0);
		bus(1, 2'h0, 32'h18);
		dly <= 8'h03;
		run_ex(32'h11, 2'h0); chk(tx_code4d_o, 1'b1);
		wait (tx_train_o == 2'h3);
		wait (tx_train_o == 2'h0);
		bus(1, 2'h0, 32'h18);
		line_loss_i <= 8'h07;
		run_ex(32'h3D, 2'h2);
		wait (tx_wake_o == 2'h2);
		wait (tx_wake_o == 2'h0);
		pulse(2'h1, 1'b0);
		wait (tx_train_o != 2'h0); chk(tx_train_o, 2'h1);
		wait (tx_train_o == 2'h0);
		bus(0, 2'h1, 0); chk(q & 32'h138F, 32'h1385);
		bus(1, 2'h0, 32'h18);
		mute <= 2'h3;
		bus(1, 2'h0, 32'h0B);
		pulse(2'h1, 1'b0);
		wait (tx_wake_o == 2'h1);
		wait (tx_wake_o == 2'h0);
		pulse(2'h2, 1'b0);
		wait (tx_wake_o == 2'h2);
		wait (tx_wake_o == 2'h0);
		tb_train <= 2'h3;
		repeat (3) @(posedge clk_i);
		chk(|tx_train_o, 1'b1);
		wait (tx_train_o == 2'h0);
		tb_train <= 2'h0;
		reset;
		bus(1, 2'h0, 32'h0B);
		pulse(2'h1, 1'b0);
		wait (tx_wake_o == 2'h1);
		wait (tx_wake_o == 2'h0);
		wait (tx_wake_o == 2'h1);
		wait (tx_wake_o == 2'h0);
		reset;
		bus(1, 2'h0, 32'h1B);
		pulse(2'h1, 1'b1);
		repeat (40) @(posedge clk_i);
		chk(tx_wake_o, 2'h0);
		pulse(2'h1, 1'b1);
		wait (tx_wake_o == 2'h1); chk(tx_code4d_o, 1'b1);
		wait (tx_wake_o == 2'h0);
		close_out;
	end
endmodule // dsl_activation_alerting_tb_top
bind dsl_activation_alerting dsl_activation_alerting_checker #(
	.WAKE_LEN(WAKE_LEN), .TRAIN_EX_SYM(TRAIN_EX_SYM),
	.TRAIN_CU_SYM(TRAIN_CU_SYM)) chk_i (.clk_i(clk_i), .rst_i(rst_i),
	.ce_i(ce_i),
	.sym_tick_i(sym_tick_i), .avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
	.tx_wake_o(tx_wake_o), .tx_train_o(tx_train_o),
	.high_power_mode_o(high_power_mode_o), .alerted_o(alerted_o));
